// ==== hdl/e3om_monitor.sv ====
// receive overhead monitor for one e3 g.832 channel with an apb register slave
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module e3om_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic frame_strobe,
	input wire logic [7:0] maintenance_adaptation_byte,
	input wire logic alignment_error,
	output logic irq
);
	import e3om_pkg::*;

	logic [2:0] received_payload_kind_q;
	logic [2:0] expected_payload_kind_q;
	logic far_fail_count_select_q;
	logic timing_marker_count_select_q;
	logic frame_loss_time_select_q;
	logic revision_1998_q;
	logic far_end_fail_flag_q;
	logic timing_marker_validated_q;
	logic frame_loss_flag_q;
	logic out_of_alignment_flag_q;
	logic payload_kind_unstable_q;
	logic [E3OM_IRQ_WIDTH-1:0] irq_stat_q;
	logic [E3OM_IRQ_WIDTH-1:0] irq_mask_q;
	logic [E3OM_IRQ_WIDTH-1:0] irq_event;
	logic [2:0] ferf_run_q;
	logic [2:0] tmark_run_q;
	logic tmark_last_q;
	logic [2:0] oof_run_q;
	logic [4:0] lof_run_q;
	logic [2:0] pld_same_q;
	logic [2:0] ferf_need;
	logic [2:0] tmark_need;
	logic [4:0] lof_need;
	logic ma_ferf;
	logic ma_tmark;
	logic [2:0] ma_pld;
	logic in_frame_strobe;
	logic wr_en;
	logic rd_en;
	logic addr_hit;
	logic ferf_set;
	logic ferf_clr;

	// apb: zero wait states, unmapped addresses answer with pslverr
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !pwrite;
	assign addr_hit = (paddr == E3OM_CFG_ONE_ADDR) || (paddr == E3OM_CFG_TWO_ADDR) ||
		(paddr == E3OM_IRQ_STAT_ADDR) || (paddr == E3OM_IRQ_MASK_ADDR) ||
		(paddr == E3OM_MODE_ADDR);
	assign pslverr = psel && penable && !addr_hit;

	assign ma_ferf = maintenance_adaptation_byte[E3OM_MA_FERF_BIT];
	assign ma_tmark = maintenance_adaptation_byte[E3OM_MA_TMARK_BIT];
	assign ma_pld = maintenance_adaptation_byte[E3OM_MA_PLD_LSB +: 3];
	// maintenance byte is only trusted while aligned
	// so the first good frame after out of frame only serves to regain alignment
	assign in_frame_strobe = frame_strobe && !out_of_alignment_flag_q;

	assign ferf_need = far_fail_count_select_q ? E3OM_LONG_COUNT : E3OM_SHORT_COUNT;
	// the 1998 revision forces the short marker count
	assign tmark_need = (timing_marker_count_select_q && !revision_1998_q) ?
		E3OM_LONG_COUNT : E3OM_SHORT_COUNT;
	assign lof_need = frame_loss_time_select_q ? E3OM_LOF_SHORT_FRAMES : E3OM_LOF_LONG_FRAMES;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			expected_payload_kind_q <= E3OM_CFG_ONE_RESET[2:0];
			far_fail_count_select_q <= E3OM_CFG_ONE_RESET[E3OM_FERF_SEL_BIT];
			timing_marker_count_select_q <= E3OM_CFG_ONE_RESET[E3OM_TMARK_SEL_BIT];
			frame_loss_time_select_q <= E3OM_CFG_TWO_RESET[E3OM_LOF_SEL_BIT];
			revision_1998_q <= 1'b0;
			irq_mask_q <= '0;
		end else if (wr_en) begin
			case (paddr)
				E3OM_CFG_ONE_ADDR: begin
					expected_payload_kind_q <= pwdata[2:0];
					far_fail_count_select_q <= pwdata[E3OM_FERF_SEL_BIT];
					timing_marker_count_select_q <= pwdata[E3OM_TMARK_SEL_BIT];
				end
				E3OM_CFG_TWO_ADDR: begin
					frame_loss_time_select_q <= pwdata[E3OM_LOF_SEL_BIT];
				end
				E3OM_IRQ_MASK_ADDR: begin
					irq_mask_q <= pwdata[E3OM_IRQ_WIDTH-1:0];
				end
				E3OM_MODE_ADDR: begin
					revision_1998_q <= pwdata[0];
				end
				default: begin
				end
			endcase
		end
	end

	// payload kind capture and stability window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			received_payload_kind_q <= E3OM_CFG_ONE_RESET[E3OM_PLD_LSB +: 3];
			pld_same_q <= 3'h0;
			payload_kind_unstable_q <= E3OM_CFG_TWO_RESET[2];
		end else if (in_frame_strobe) begin
			received_payload_kind_q <= ma_pld;
			if (ma_pld != received_payload_kind_q) begin
				pld_same_q <= 3'h0;
				payload_kind_unstable_q <= 1'b1;
			end else if (pld_same_q + 3'h1 < E3OM_UNSTAB_FRAMES - 3'h1) begin
				pld_same_q <= pld_same_q + 3'h1;
			end else begin
				// five equal frames in a row: one seed plus four repeats
				payload_kind_unstable_q <= 1'b0;
			end
		end
	end

	// far-end failure: count frames whose bit disagrees with the current flag
	assign ferf_set = in_frame_strobe && ma_ferf && !far_end_fail_flag_q &&
		(ferf_run_q + 3'h1 >= ferf_need);
	assign ferf_clr = in_frame_strobe && !ma_ferf && far_end_fail_flag_q &&
		(ferf_run_q + 3'h1 >= ferf_need);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ferf_run_q <= 3'h0;
			far_end_fail_flag_q <= E3OM_CFG_TWO_RESET[0];
		end else if (in_frame_strobe) begin
			if (ma_ferf == far_end_fail_flag_q || ferf_set || ferf_clr) begin
				ferf_run_q <= 3'h0;
			end else begin
				ferf_run_q <= ferf_run_q + 3'h1;
			end
			if (ferf_set) begin
				far_end_fail_flag_q <= 1'b1;
			end else if (ferf_clr) begin
				far_end_fail_flag_q <= 1'b0;
			end
		end
	end

	// timing marker: run length of the current received state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmark_run_q <= 3'h0;
			tmark_last_q <= 1'b0;
			timing_marker_validated_q <= E3OM_CFG_TWO_RESET[E3OM_TMARK_BIT];
		end else if (in_frame_strobe) begin
			tmark_last_q <= ma_tmark;
			if (ma_tmark != tmark_last_q || tmark_run_q == 3'h0) begin
				tmark_run_q <= 3'h1;
			end else if (tmark_run_q < E3OM_LONG_COUNT) begin
				tmark_run_q <= tmark_run_q + 3'h1;
			end
			if (ma_tmark == tmark_last_q && tmark_run_q != 3'h0 &&
				tmark_run_q + 3'h1 >= tmark_need) begin
				timing_marker_validated_q <= ma_tmark;
			end
		end
	end

	// alignment loss and frame-loss timing, counted in frame periods
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oof_run_q <= 3'h0;
			out_of_alignment_flag_q <= E3OM_CFG_TWO_RESET[5];
			lof_run_q <= 5'h00;
			frame_loss_flag_q <= E3OM_CFG_TWO_RESET[6];
		end else if (frame_strobe) begin
			if (!alignment_error) begin
				oof_run_q <= 3'h0;
				out_of_alignment_flag_q <= 1'b0;
			end else if (oof_run_q + 3'h1 >= E3OM_OOF_COUNT) begin
				out_of_alignment_flag_q <= 1'b1;
			end else begin
				oof_run_q <= oof_run_q + 3'h1;
			end
			// lof drops one frame after oof clears, as it reads the registered flag
			if (!out_of_alignment_flag_q) begin
				lof_run_q <= 5'h00;
				frame_loss_flag_q <= 1'b0;
			end else if (lof_run_q + 5'h01 >= lof_need) begin
				frame_loss_flag_q <= 1'b1;
			end else begin
				lof_run_q <= lof_run_q + 5'h01;
			end
		end
	end

	// mismatch is silenced in 1998 mode
	assign irq_event[E3OM_IRQ_MISMATCH] = in_frame_strobe && !revision_1998_q &&
		(ma_pld != expected_payload_kind_q);
	assign irq_event[E3OM_IRQ_FERF] = ferf_set || ferf_clr;
	assign irq_event[E3OM_IRQ_OOF] = frame_strobe && alignment_error && !out_of_alignment_flag_q &&
		(oof_run_q + 3'h1 >= E3OM_OOF_COUNT);
	assign irq_event[E3OM_IRQ_LOF] = frame_strobe && out_of_alignment_flag_q && !frame_loss_flag_q &&
		(lof_run_q + 5'h01 >= lof_need);

	// a new event wins over a write-one-to-clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~((wr_en && paddr == E3OM_IRQ_STAT_ADDR) ?
				pwdata[E3OM_IRQ_WIDTH-1:0] : '0)) | irq_event;
		end
	end
	// a plain level: it stays up until software clears or masks the cause
	assign irq = |(irq_stat_q & irq_mask_q);

	// bits 4 and 3 of config/status two have no source in this block and read as zero
	always_comb begin
		prdata = 32'h0000_0000;
		if (rd_en) begin
			case (paddr)
				E3OM_CFG_ONE_ADDR: prdata[7:0] = {received_payload_kind_q, far_fail_count_select_q,
					timing_marker_count_select_q, expected_payload_kind_q};
				E3OM_CFG_TWO_ADDR: prdata[7:0] = {frame_loss_time_select_q, frame_loss_flag_q,
					out_of_alignment_flag_q, 2'b00, payload_kind_unstable_q,
					timing_marker_validated_q, far_end_fail_flag_q};
				E3OM_IRQ_STAT_ADDR: prdata[E3OM_IRQ_WIDTH-1:0] = irq_stat_q;
				E3OM_IRQ_MASK_ADDR: prdata[E3OM_IRQ_WIDTH-1:0] = irq_mask_q;
				E3OM_MODE_ADDR: prdata[0] = revision_1998_q;
				default: prdata = 32'h0000_0000;
			endcase
		end
	end

	// a frame whose failure bit disagrees with the declared state
	sequence ferf_flip_s;
		in_frame_strobe && (ma_ferf != far_end_fail_flag_q);
	endsequence

	// a payload kind that differs from the one captured last
	sequence pld_change_s;
		in_frame_strobe && (ma_pld != received_payload_kind_q);
	endsequence

	// a frame with both alignment bytes in error
	sequence align_bad_s;
		frame_strobe && alignment_error;
	endsequence

	// all checks sleep during reset, when the flags sit at their reset levels
	mismatch_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
		(in_frame_strobe && !revision_1998_q && ma_pld != expected_payload_kind_q)
		|=> irq_stat_q[E3OM_IRQ_MISMATCH]) else $error("mismatch not flagged");
	mismatch_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
		(irq_stat_q[E3OM_IRQ_MISMATCH] &&
		!(wr_en && paddr == E3OM_IRQ_STAT_ADDR && pwdata[E3OM_IRQ_MISMATCH]))
		|=> irq_stat_q[E3OM_IRQ_MISMATCH]) else $error("mismatch status lost");
	rev98_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		revision_1998_q |-> !irq_event[E3OM_IRQ_MISMATCH]) else $error("mismatch in 1998 mode");
	pld_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
		in_frame_strobe |=> received_payload_kind_q == $past(ma_pld)) else $error("kind lost");
	ferf_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(far_end_fail_flag_q) |-> $past(ferf_run_q) == ferf_need - 3'h1)
		else $error("far fail count wrong");
	ferf_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(far_end_fail_flag_q) |-> $past(ferf_run_q) == ferf_need - 3'h1)
		else $error("far fail clear count wrong");
	ferf_early_a: assert property (@(posedge pclk) disable iff (!presetn)
		ferf_flip_s ##0 (ferf_run_q + 3'h1 < ferf_need) |=> $stable(far_end_fail_flag_q))
		else $error("far fail flipped early");
	ferf_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
		!in_frame_strobe |=> $stable(far_end_fail_flag_q)) else $error("far fail moved");
	tmark_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(timing_marker_validated_q) |-> timing_marker_validated_q == $past(tmark_last_q))
		else $error("marker state wrong");
	tmark_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
		!in_frame_strobe |=> $stable(timing_marker_validated_q)) else $error("marker moved");
	tmark_need_a: assert property (@(posedge pclk) disable iff (!presetn)
		revision_1998_q |-> tmark_need == E3OM_SHORT_COUNT) else $error("1998 count");
	lof_time_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(frame_loss_flag_q) |-> $past(lof_run_q) == lof_need - 5'h01 &&
		$past(out_of_alignment_flag_q)) else $error("loss of frame timing");
	lof_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(frame_strobe && !out_of_alignment_flag_q) |=> !frame_loss_flag_q)
		else $error("loss of frame kept in frame");
	oof_decl_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(out_of_alignment_flag_q) |-> $past(oof_run_q) == E3OM_OOF_COUNT - 3'h1)
		else $error("out of frame count");
	oof_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		align_bad_s ##0 out_of_alignment_flag_q |=> out_of_alignment_flag_q)
		else $error("out of frame dropped");
	oof_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(frame_strobe && !alignment_error) |=> !out_of_alignment_flag_q)
		else $error("out of frame kept");
	unstab_a: assert property (@(posedge pclk) disable iff (!presetn)
		pld_change_s |=> payload_kind_unstable_q) else $error("unstable not set");
	unstab_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(payload_kind_unstable_q) |-> $past(in_frame_strobe) &&
		$past(ma_pld) == $past(received_payload_kind_q)) else $error("unstable cleared on change");
	oof_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		out_of_alignment_flag_q |=> $stable(received_payload_kind_q)) else $error("used while oof");
endmodule : e3om_monitor
`default_nettype wire

// ==== hdl/e3om_pkg.sv ====
// package of constants for the e3 g.832 receive overhead monitor
package e3om_pkg;
	// printed offsets are word indices; the apb byte address is four times the index
	localparam logic [11:0] E3OM_CFG_ONE_INDEX = 12'h010;
	localparam logic [11:0] E3OM_CFG_TWO_INDEX = 12'h011;
	localparam logic [11:0] E3OM_CFG_ONE_ADDR = E3OM_CFG_ONE_INDEX << 2;
	localparam logic [11:0] E3OM_CFG_TWO_ADDR = E3OM_CFG_TWO_INDEX << 2;
	localparam logic [11:0] E3OM_IRQ_STAT_ADDR = 12'h0048;
	localparam logic [11:0] E3OM_IRQ_MASK_ADDR = 12'h004c;
	localparam logic [11:0] E3OM_MODE_ADDR = 12'h0050;
	localparam logic [7:0] E3OM_CFG_ONE_RESET = 8'h00;
	localparam logic [7:0] E3OM_CFG_TWO_RESET = 8'h7f;
	localparam int E3OM_PLD_LSB = 5;
	localparam int E3OM_FERF_SEL_BIT = 4;
	localparam int E3OM_TMARK_SEL_BIT = 3;
	localparam int E3OM_LOF_SEL_BIT = 7;
	localparam int E3OM_TMARK_BIT = 1;
	localparam int E3OM_MA_FERF_BIT = 7;
	localparam int E3OM_MA_PLD_LSB = 3;
	localparam int E3OM_MA_TMARK_BIT = 0;
	localparam logic [2:0] E3OM_SHORT_COUNT = 3'h3;
	localparam logic [2:0] E3OM_LONG_COUNT = 3'h5;
	localparam logic [2:0] E3OM_OOF_COUNT = 3'h4;
	localparam logic [2:0] E3OM_UNSTAB_FRAMES = 3'h5;
	localparam logic [4:0] E3OM_LOF_LONG_FRAMES = 5'h18;
	localparam logic [4:0] E3OM_LOF_SHORT_FRAMES = 5'h08;
	localparam int E3OM_IRQ_MISMATCH = 0;
	localparam int E3OM_IRQ_FERF = 1;
	localparam int E3OM_IRQ_OOF = 2;
	localparam int E3OM_IRQ_LOF = 3;
	localparam int E3OM_IRQ_WIDTH = 4;
endpackage : e3om_pkg

// ==== tb/e3om_far_end.sv ====
// far-end terminal model: one frame per request, its lines scrambled between frames
`timescale 1ns/1ps
`default_nettype none
module e3om_far_end (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic send,
	input wire logic [7:0] ma_in,
	input wire logic err_in,
	output logic frame_strobe,
	output logic [7:0] maintenance_adaptation_byte,
	output logic alignment_error
);
	// between frames the lines invert on every cycle, so a stale byte is never mistaken for data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_strobe <= 1'b0;
			maintenance_adaptation_byte <= 8'h00;
			alignment_error <= 1'b0;
		end else begin
			frame_strobe <= send;
			maintenance_adaptation_byte <= send ? ma_in : ~maintenance_adaptation_byte;
			alignment_error <= send ? err_in : ~alignment_error;
		end
	end
endmodule : e3om_far_end
`default_nettype wire

// ==== tb/e3_g832_rx_overhead_monitor_tb.sv ====
// self-checking bench for the e3 receive overhead monitor
`timescale 1ns/1ps
`default_nettype none
module e3_g832_rx_overhead_monitor_tb;
	import e3om_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic send = 0, err_in = 0, fs, ae;
	logic [7:0] ma_in = 0, mab;
	int error_cnt = 0, num_checks = 0, cycles = 0;
	e3om_monitor i_e3om_monitor (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .frame_strobe(fs), .maintenance_adaptation_byte(mab),
		.alignment_error(ae), .irq(irq));
	e3om_far_end i_e3om_far_end (.pclk(pclk), .presetn(presetn), .send(send), .ma_in(ma_in),
		.err_in(err_in), .frame_strobe(fs), .maintenance_adaptation_byte(mab),
		.alignment_error(ae));
	always #10 pclk = ~pclk;
	task stop_test;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : stop_test
	// the whole run needs roughly five hundred cycles
	always @(posedge pclk) begin
		cycles++;
		if (cycles > 20000) begin
			error_cnt++;
			stop_test();
		end
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task fld(input string nm, input logic [11:0] a, input int lsb, input logic [31:0] m,
		input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		chk(nm, (r >> lsb) & m, exp);
	endtask : fld
	task irqchk(input logic exp);
		@(posedge pclk);
		chk("irq", {31'h0000_0000, irq}, {31'h0000_0000, exp});
	endtask : irqchk
	task frames(input int n, input logic [7:0] b, input logic e);
		repeat (n) begin
			@(posedge pclk);
			send <= 1'b1;
			ma_in <= b;
			err_in <= e;
			@(posedge pclk);
			send <= 1'b0;
			@(posedge pclk);
		end
	endtask : frames
	task t_reset;
		logic [31:0] r;
		logic e;
		fld("cfg1", E3OM_CFG_ONE_ADDR, 0, 32'hffff_ffff, 32'h0000_0000);
		fld("cfg2", E3OM_CFG_TWO_ADDR, 0, 32'hffff_ffff, 32'h0000_0067);
		apb(1'b0, 12'h0ff0, 32'h0000_0000, r, e);
		chk("unmapped", {r[30:0], e}, 32'h0000_0001);
	endtask : t_reset
	task t_payload;
		wr(E3OM_IRQ_MASK_ADDR, 32'h0000_000f);
		wr(E3OM_CFG_ONE_ADDR, 32'h0000_0002);
		frames(1, 8'h10, 1'b0);
		fld("mismatch", E3OM_IRQ_STAT_ADDR, 0, 32'h0000_0001, 32'h0000_0000);
		frames(1, 8'h28, 1'b0);
		fld("kind", E3OM_CFG_ONE_ADDR, 5, 32'h0000_0007, 32'h0000_0005);
		fld("mismatch", E3OM_IRQ_STAT_ADDR, 0, 32'h0000_0001, 32'h0000_0001);
		fld("unstable", E3OM_CFG_TWO_ADDR, 2, 32'h0000_0001, 32'h0000_0001);
		irqchk(1'b1);
		frames(3, 8'h28, 1'b0);
		fld("unstable", E3OM_CFG_TWO_ADDR, 2, 32'h0000_0001, 32'h0000_0001);
		frames(1, 8'h28, 1'b0);
		fld("unstable", E3OM_CFG_TWO_ADDR, 2, 32'h0000_0001, 32'h0000_0000);
		wr(E3OM_IRQ_MASK_ADDR, 32'h0000_0000);
		irqchk(1'b0);
		wr(E3OM_IRQ_MASK_ADDR, 32'h0000_000f);
		wr(E3OM_IRQ_STAT_ADDR, 32'h0000_000f);
		irqchk(1'b0);
		wr(E3OM_MODE_ADDR, 32'h0000_0001);
		frames(1, 8'h30, 1'b0);
		fld("kind", E3OM_CFG_ONE_ADDR, 5, 32'h0000_0007, 32'h0000_0006);
		fld("mismatch", E3OM_IRQ_STAT_ADDR, 0, 32'h0000_0001, 32'h0000_0000);
		wr(E3OM_MODE_ADDR, 32'h0000_0000);
	endtask : t_payload
	task t_fail;
		for (int s = 0; s < 2; s++) begin
			wr(E3OM_CFG_ONE_ADDR, 32'(s) << E3OM_FERF_SEL_BIT);
			wr(E3OM_IRQ_STAT_ADDR, 32'h0000_000f);
			frames(s ? 4 : 2, 8'h80, 1'b0);
			fld("far fail", E3OM_CFG_TWO_ADDR, 0, 32'h0000_0001, 32'h0000_0000);
			fld("far fail irq", E3OM_IRQ_STAT_ADDR, 1, 32'h0000_0001, 32'h0000_0000);
			frames(1, 8'h80, 1'b0);
			fld("far fail", E3OM_CFG_TWO_ADDR, 0, 32'h0000_0001, 32'h0000_0001);
			fld("far fail irq", E3OM_IRQ_STAT_ADDR, 1, 32'h0000_0001, 32'h0000_0001);
			frames(s ? 4 : 2, 8'h00, 1'b0);
			fld("far fail", E3OM_CFG_TWO_ADDR, 0, 32'h0000_0001, 32'h0000_0001);
			frames(1, 8'h00, 1'b0);
			fld("far fail", E3OM_CFG_TWO_ADDR, 0, 32'h0000_0001, 32'h0000_0000);
		end
	endtask : t_fail
	task t_marker;
		// third case: long select but 1998 mode, which must fall back to the short count
		for (int c = 0; c < 3; c++) begin
			wr(E3OM_MODE_ADDR, {31'h0000_0000, c == 2});
			wr(E3OM_CFG_ONE_ADDR, 32'(c > 0) << E3OM_TMARK_SEL_BIT);
			frames(5, 8'h00, 1'b0);
			frames(c == 1 ? 4 : 2, 8'h01, 1'b0);
			fld("marker", E3OM_CFG_TWO_ADDR, 1, 32'h0000_0001, 32'h0000_0000);
			frames(1, 8'h01, 1'b0);
			fld("marker", E3OM_CFG_TWO_ADDR, 1, 32'h0000_0001, 32'h0000_0001);
		end
		wr(E3OM_MODE_ADDR, 32'h0000_0000);
	endtask : t_marker
	task t_lof;
		for (int s = 0; s < 2; s++) begin
			wr(E3OM_CFG_TWO_ADDR, 32'(s) << E3OM_LOF_SEL_BIT);
			frames(3, 8'h00, 1'b1);
			fld("oof", E3OM_CFG_TWO_ADDR, 5, 32'h0000_0001, 32'h0000_0000);
			frames(1, 8'h00, 1'b1);
			fld("oof", E3OM_CFG_TWO_ADDR, 5, 32'h0000_0001, 32'h0000_0001);
			frames(s ? 7 : 23, 8'h38, 1'b1);
			fld("lof", E3OM_CFG_TWO_ADDR, 6, 32'h0000_0001, 32'h0000_0000);
			frames(1, 8'h38, 1'b1);
			fld("lof", E3OM_CFG_TWO_ADDR, 6, 32'h0000_0001, 32'h0000_0001);
			fld("kind", E3OM_CFG_ONE_ADDR, 5, 32'h0000_0007, 32'h0000_0000);
			fld("oof lof irq", E3OM_IRQ_STAT_ADDR, 2, 32'h0000_0003, 32'h0000_0003);
			frames(1, 8'h00, 1'b0);
			fld("oof", E3OM_CFG_TWO_ADDR, 5, 32'h0000_0001, 32'h0000_0000);
			frames(1, 8'h00, 1'b0);
			fld("oof lof", E3OM_CFG_TWO_ADDR, 5, 32'h0000_0003, 32'h0000_0000);
			wr(E3OM_IRQ_STAT_ADDR, 32'h0000_000f);
		end
	endtask : t_lof
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_payload();
		t_fail();
		t_marker();
		t_lof();
		stop_test();
	end
endmodule : e3_g832_rx_overhead_monitor_tb
`default_nettype wire
